// ### rtl/ntb_cap_defines.svh
`ifndef NTB_CAP_DEFINES_SVH
`define NTB_CAP_DEFINES_SVH

// configuration byte offsets of the bank
`define IRQ_ROUTING_OFFSET   12'h03C
`define IRQ_PIN_OFFSET       12'h03D
`define MIN_GRANT_OFFSET     12'h03E
`define MAX_LATENCY_OFFSET   12'h03F
`define CAP_HEADER_OFFSET    12'h040
`define DEV_CAP_OFFSET       12'h044

// window spans 4 KB of config space
`define CFG_WINDOW_LSB       12

// reset and hardwired values
`define IRQ_ROUTING_RST      8'h00
`define IRQ_PIN_RST          8'h00
`define MIN_GRANT_VAL        8'h00
`define MAX_LATENCY_VAL      8'h00
`define CAPABILITY_ID_VAL    8'h10
`define NEXT_CAP_PTR_VAL     8'h64
`define CAP_VERSION_VAL      4'h1
`define PORT_TYPE_RST        4'h0
`define SLOT_IMPL_RST        1'h0
`define IRQ_MSG_NUM_VAL      5'h00
`define MAX_PAYLOAD_RST      3'h4
`define PHANTOM_FN_VAL       2'h0
`define EXT_TAG_VAL          1'h1
`define L0S_LATENCY_VAL      3'h7
`define L1_LATENCY_VAL       3'h7
`define INDICATORS_RST       3'h0

// field positions inside the capability header word
`define CAP_ID_LSB           0
`define NEXT_PTR_LSB         8
`define CAP_VER_LSB          16
`define PORT_TYPE_LSB        20
`define SLOT_IMPL_BIT        24
`define IRQ_MSG_NUM_LSB      25

// field positions inside the device capabilities word
`define MAX_PAYLOAD_LSB      0
`define PHANTOM_FN_LSB       3
`define EXT_TAG_BIT          5
`define L0S_LATENCY_LSB      6
`define L1_LATENCY_LSB       9
`define INDICATORS_LSB       12

`endif

// ### rtl/ntb_cap_pkg.sv
`default_nettype none
package ntb_cap_pkg;

   // access sequencer states, one-hot
   typedef enum logic [2:0] {
      ARB_IDLE  = 3'b001,
      ARB_ISSUE = 3'b010,
      ARB_WAIT  = 3'b100
   } arb_state_e;

   // which requester owns the current access, one-hot
   typedef enum logic [1:0] {
      SRC_CFG = 2'b01,
      SRC_MEM = 2'b10
   } access_src_e;

   // sequencer state
   typedef struct packed {
      arb_state_e  state;
      access_src_e src;
      logic        hit;
      logic        wr;
      logic [9:0]  dw;
      logic [31:0] wdata;
      logic [3:0]  be;
   } arb_s;

   // register bank state
   typedef struct packed {
      logic [7:0]  irq_routing;
      logic        cfg_ack;
      logic [31:0] cfg_rdata;
      logic        mem_ack;
      logic [31:0] mem_rdata;
   } regs_s;

endpackage : ntb_cap_pkg
`default_nettype wire

// ### rtl/cfg_access_if.sv
`timescale 1ns/1ps
`default_nettype none
// one granted register access, valid for a single cycle
interface cfg_access_if;
   logic                     valid;    // access pulse
   logic                     wr;       // write when high
   logic                     hit;      // address lies in the bank's space
   logic [9:0]               dw_index; // dword index in configuration space
   logic [31:0]              wdata;    // write data
   logic [3:0]               be;       // byte enables of a write
   ntb_cap_pkg::access_src_e src;      // owner of the access

   modport arb  (output valid, wr, hit, dw_index, wdata, be, src);
   modport regs (input  valid, wr, hit, dw_index, wdata, be, src);
endinterface : cfg_access_if
`default_nettype wire

// ### rtl/cfg_access_arb.sv
`timescale 1ns/1ps
`default_nettype none
`include "ntb_cap_defines.svh"
module cfg_access_arb (
   // clock and reset
   input  wire logic        ref_clk,
   input  wire logic        resetn,
   // configuration requester
   input  wire logic        cfg_req,
   input  wire logic        cfg_wr,
   input  wire logic [11:0] cfg_addr,
   input  wire logic [31:0] cfg_wdata,
   input  wire logic [3:0]  cfg_be,
   // memory window requester
   input  wire logic        mem_req,
   input  wire logic        mem_wr,
   input  wire logic [31:0] mem_addr,
   input  wire logic [31:0] mem_wdata,
   input  wire logic [3:0]  mem_be,
   input  wire logic [19:0] window_base_hi,
   // granted access
   cfg_access_if.arb        acc
);

   ntb_cap_pkg::arb_s st_ff;   // registered state
   ntb_cap_pkg::arb_s nxt_st;  // next state
   logic              own_req; // request line of the current owner

   assign own_req = (st_ff.src == ntb_cap_pkg::SRC_CFG) ? cfg_req : mem_req;

   // one grant at a time; config wins a tie
   // so enumeration is never starved
   always_comb begin
      nxt_st = st_ff;
      case (st_ff.state)
         ntb_cap_pkg::ARB_IDLE: begin
            if (cfg_req) begin
               nxt_st.state = ntb_cap_pkg::ARB_ISSUE;
               nxt_st.src   = ntb_cap_pkg::SRC_CFG;
               nxt_st.hit   = 1'b1;
               nxt_st.wr    = cfg_wr;
               nxt_st.dw    = cfg_addr[11:2];
               nxt_st.wdata = cfg_wdata;
               nxt_st.be    = cfg_be;
            end else if (mem_req) begin
               nxt_st.state = ntb_cap_pkg::ARB_ISSUE;
               nxt_st.src   = ntb_cap_pkg::SRC_MEM;
               // the window maps the whole configuration space RL18
               nxt_st.hit   = (mem_addr[31:`CFG_WINDOW_LSB] == window_base_hi);
               nxt_st.wr    = mem_wr;
               nxt_st.dw    = mem_addr[11:2];
               nxt_st.wdata = mem_wdata;
               nxt_st.be    = mem_be;
            end
         end
         // access pulse lasts exactly this one cycle
         ntb_cap_pkg::ARB_ISSUE: nxt_st.state = ntb_cap_pkg::ARB_WAIT;
         // hold off until the owner drops its request
         ntb_cap_pkg::ARB_WAIT: begin
            if (!own_req) begin
               nxt_st.state = ntb_cap_pkg::ARB_IDLE;
            end
         end
         default: nxt_st.state = ntb_cap_pkg::ARB_IDLE;
      endcase
   end

   // state register
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         st_ff <= '{state: ntb_cap_pkg::ARB_IDLE, src: ntb_cap_pkg::SRC_CFG, default: '0};
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign acc.valid    = (st_ff.state == ntb_cap_pkg::ARB_ISSUE);
   assign acc.wr       = st_ff.wr;
   assign acc.hit      = st_ff.hit;
   assign acc.dw_index = st_ff.dw;
   assign acc.wdata    = st_ff.wdata;
   assign acc.be       = st_ff.be;
   assign acc.src      = st_ff.src;

endmodule : cfg_access_arb
`default_nettype wire

// ### rtl/lockable_field.sv
`timescale 1ns/1ps
`default_nettype none
// field set by the loader, or by software when allowed and unlocked
module lockable_field #(
   parameter int               W     = 1,
   parameter logic [W-1:0]     RST   = '0,
   parameter logic             SW_OK = 1'b1
) (
   // clock and reset
   input  wire logic         ref_clk,
   input  wire logic         resetn,
   // software side
   input  wire logic         sw_we,
   input  wire logic         sw_lock,
   input  wire logic [W-1:0] sw_d,
   // loader side
   input  wire logic         ld_we,
   input  wire logic [W-1:0] ld_d,
   // current value
   output logic      [W-1:0] q
);

   typedef struct packed {
      logic [W-1:0] val;
   } field_s;

   field_s st_ff;  // registered state
   field_s nxt_st; // next state

   // loader beats software so eeprom defaults
   // survive a racing write
   always_comb begin
      nxt_st = st_ff;
      if (ld_we) begin
         nxt_st.val = ld_d;
      end else if (sw_we && SW_OK && !sw_lock) begin
         nxt_st.val = sw_d;
      end
   end

   // state register
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         st_ff.val <= RST;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign q = st_ff.val;

endmodule : lockable_field
`default_nettype wire

// ### rtl/nt_bridge_pcie_cap_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "ntb_cap_defines.svh"
// Notes on behaviour
// RL1 - routing byte is plain storage, reset zero
// RL2 - no legacy interrupts; pin byte lockable, zero
// RL3 - minimum grant reads zero, writes ignored
// RL4 - maximum latency reads zero, writes ignored
// RL5 - capability identifier fixed at sixteen
// RL6 - next capability pointer fixed at 0x64
// RL7 - capability version fixed at one
// RL8 - lockable port type, endpoint default, loader override
// RL9 - lockable slot implemented bit, reset zero
// RL10 - interrupt message number reads zero
// RL11 - lockable max payload supported, reset four
// RL12 - phantom functions field hardwired zero
// RL13 - extended tag support hardwired one
// RL14 - L0s acceptable latency reads seven
// RL15 - L1 acceptable latency reads seven
// RL16 - indicator present bits, loader may set
// RL17 - reserved bits read zero, writes dropped
// RL18 - bank also reachable through memory window
module nt_bridge_pcie_cap_regs (
   // clock and reset
   input  wire logic        ref_clk,
   input  wire logic        resetn,
   // configuration access port
   input  wire logic        cfg_req,
   input  wire logic        cfg_wr,
   input  wire logic [11:0] cfg_addr,
   input  wire logic [31:0] cfg_wdata,
   input  wire logic [3:0]  cfg_be,
   output logic             cfg_ack,
   output logic      [31:0] cfg_rdata,
   // memory-mapped configuration window
   input  wire logic        mem_req,
   input  wire logic        mem_wr,
   input  wire logic [31:0] mem_addr,
   input  wire logic [31:0] mem_wdata,
   input  wire logic [3:0]  mem_be,
   input  wire logic [19:0] window_base_hi,
   output logic             mem_ack,
   output logic      [31:0] mem_rdata,
   // write lock for lockable fields
   input  wire logic        regs_locked,
   // serial eeprom loader
   input  wire logic        eeprom_ld,
   input  wire logic [11:0] eeprom_ld_addr,
   input  wire logic [31:0] eeprom_ld_data,
   input  wire logic [3:0]  eeprom_ld_be,
   // capability values for the rest of the bridge
   output logic      [3:0]  port_type,
   output logic             slot_implemented,
   output logic      [2:0]  max_payload_supported,
   output logic             attention_button_present,
   output logic             attention_indicator_present,
   output logic             power_indicator_present
);

   // typed offsets, so fields can be sliced
   localparam logic [11:0] ROUTING_OFF = `IRQ_ROUTING_OFFSET;
   localparam logic [11:0] PIN_OFF     = `IRQ_PIN_OFFSET;
   localparam logic [11:0] GRANT_OFF   = `MIN_GRANT_OFFSET;
   localparam logic [11:0] LATENCY_OFF = `MAX_LATENCY_OFFSET;
   localparam logic [11:0] CAP_OFF     = `CAP_HEADER_OFFSET;
   localparam logic [11:0] DCAP_OFF    = `DEV_CAP_OFFSET;

   // dword indices of the bank
   localparam logic [9:0]  LEGACY_DW   = ROUTING_OFF[11:2];
   localparam logic [9:0]  CAP_DW      = CAP_OFF[11:2];
   localparam logic [9:0]  DCAP_DW     = DCAP_OFF[11:2];

   // legacy tail byte lanes
   localparam logic [1:0]  ROUTING_LN  = ROUTING_OFF[1:0];
   localparam logic [1:0]  PIN_LN      = PIN_OFF[1:0];
   localparam logic [1:0]  GRANT_LN    = GRANT_OFF[1:0];
   localparam logic [1:0]  LATENCY_LN  = LATENCY_OFF[1:0];

   cfg_access_if acc ();              // granted access, one cycle wide

   ntb_cap_pkg::regs_s st_ff;         // registered state
   ntb_cap_pkg::regs_s nxt_st;        // next state

   logic        sw_write;             // software write that hits the bank
   logic        wr_legacy;            // software write to the legacy tail word
   logic        wr_cap;               // software write to the capability header
   logic        wr_dcap;              // software write to device capabilities
   logic        ld_legacy;            // loader write to the legacy tail word
   logic        ld_cap;               // loader write to the capability header
   logic        ld_dcap;              // loader write to device capabilities
   logic [7:0]  irq_pin_q;            // current interrupt pin byte
   logic [2:0]  indicators_q;         // button, indicator, power indicator
   logic [31:0] rd_legacy;            // read image of the legacy tail
   logic [31:0] rd_cap;               // read image of the capability header
   logic [31:0] rd_dcap;              // read image of device capabilities
   logic [31:0] rd_word;              // word chosen by the access index

   // request sequencing for both access paths
   cfg_access_arb u_arb (
      .ref_clk        (ref_clk),
      .resetn         (resetn),
      .cfg_req        (cfg_req),
      .cfg_wr         (cfg_wr),
      .cfg_addr       (cfg_addr),
      .cfg_wdata      (cfg_wdata),
      .cfg_be         (cfg_be),
      .mem_req        (mem_req),
      .mem_wr         (mem_wr),
      .mem_addr       (mem_addr),
      .mem_wdata      (mem_wdata),
      .mem_be         (mem_be),
      .window_base_hi (window_base_hi),
      .acc            (acc)
   );

   // write decode; window misses write nothing
   assign sw_write  = acc.valid && acc.wr && acc.hit;
   assign wr_legacy = sw_write && (acc.dw_index == LEGACY_DW);
   assign wr_cap    = sw_write && (acc.dw_index == CAP_DW);
   assign wr_dcap   = sw_write && (acc.dw_index == DCAP_DW);
   assign ld_legacy = eeprom_ld && (eeprom_ld_addr[11:2] == LEGACY_DW);
   assign ld_cap    = eeprom_ld && (eeprom_ld_addr[11:2] == CAP_DW);
   assign ld_dcap   = eeprom_ld && (eeprom_ld_addr[11:2] == DCAP_DW);

   // interrupt pin byte; no legacy interrupt is ever signalled,
   // software only reads back what it wrote RL2
   lockable_field #(
      .W     (8),
      .RST   (`IRQ_PIN_RST),
      .SW_OK (1'b1)
   ) u_irq_pin (
      .ref_clk (ref_clk),
      .resetn  (resetn),
      .sw_we   (wr_legacy && acc.be[PIN_LN]),
      .sw_lock (regs_locked),
      .sw_d    (acc.wdata[{PIN_LN, 3'h0} +: 8]),
      .ld_we   (ld_legacy && eeprom_ld_be[PIN_LN]),
      .ld_d    (eeprom_ld_data[{PIN_LN, 3'h0} +: 8]),
      .q       (irq_pin_q)
   );

   // port type, endpoint by default, eeprom may replace it RL8
   lockable_field #(
      .W     (4),
      .RST   (`PORT_TYPE_RST),
      .SW_OK (1'b1)
   ) u_port_type (
      .ref_clk (ref_clk),
      .resetn  (resetn),
      .sw_we   (wr_cap && acc.be[`PORT_TYPE_LSB / 8]),
      .sw_lock (regs_locked),
      .sw_d    (acc.wdata[`PORT_TYPE_LSB +: 4]),
      .ld_we   (ld_cap && eeprom_ld_be[`PORT_TYPE_LSB / 8]),
      .ld_d    (eeprom_ld_data[`PORT_TYPE_LSB +: 4]),
      .q       (port_type)
   );

   // slot implemented, set when a slot is fitted RL9
   lockable_field #(
      .W     (1),
      .RST   (`SLOT_IMPL_RST),
      .SW_OK (1'b1)
   ) u_slot (
      .ref_clk (ref_clk),
      .resetn  (resetn),
      .sw_we   (wr_cap && acc.be[`SLOT_IMPL_BIT / 8]),
      .sw_lock (regs_locked),
      .sw_d    (acc.wdata[`SLOT_IMPL_BIT +: 1]),
      .ld_we   (ld_cap && eeprom_ld_be[`SLOT_IMPL_BIT / 8]),
      .ld_d    (eeprom_ld_data[`SLOT_IMPL_BIT +: 1]),
      .q       (slot_implemented)
   );

   // max payload supported, 2048 bytes out of reset RL11
   lockable_field #(
      .W     (3),
      .RST   (`MAX_PAYLOAD_RST),
      .SW_OK (1'b1)
   ) u_max_payload (
      .ref_clk (ref_clk),
      .resetn  (resetn),
      .sw_we   (wr_dcap && acc.be[`MAX_PAYLOAD_LSB / 8]),
      .sw_lock (regs_locked),
      .sw_d    (acc.wdata[`MAX_PAYLOAD_LSB +: 3]),
      .ld_we   (ld_dcap && eeprom_ld_be[`MAX_PAYLOAD_LSB / 8]),
      .ld_d    (eeprom_ld_data[`MAX_PAYLOAD_LSB +: 3]),
      .q       (max_payload_supported)
   );

   // indicator bits are read-only to software;
   // only the loader changes them RL16
   lockable_field #(
      .W     (3),
      .RST   (`INDICATORS_RST),
      .SW_OK (1'b0)
   ) u_indicators (
      .ref_clk (ref_clk),
      .resetn  (resetn),
      .sw_we   (1'b0),
      .sw_lock (1'b1),
      .sw_d    (3'h0),
      .ld_we   (ld_dcap && eeprom_ld_be[`INDICATORS_LSB / 8]),
      .ld_d    (eeprom_ld_data[`INDICATORS_LSB +: 3]),
      .q       (indicators_q)
   );

   // indicators straight from flops
   assign attention_button_present    = indicators_q[0];
   assign attention_indicator_present = indicators_q[1];
   assign power_indicator_present     = indicators_q[2];

   // read images; unset bits stay zero,
   // covering reserved ranges RL17
   always_comb begin
      rd_legacy = 32'h0000_0000;
      rd_cap    = 32'h0000_0000;
      rd_dcap   = 32'h0000_0000;
      // legacy header tail
      rd_legacy[{ROUTING_LN, 3'h0} +: 8] = st_ff.irq_routing;        // RL1
      rd_legacy[{PIN_LN, 3'h0} +: 8]     = irq_pin_q;                // RL2
      rd_legacy[{GRANT_LN, 3'h0} +: 8]   = `MIN_GRANT_VAL;           // RL3
      rd_legacy[{LATENCY_LN, 3'h0} +: 8] = `MAX_LATENCY_VAL;         // RL4
      // capability header
      rd_cap[`CAP_ID_LSB +: 8]           = `CAPABILITY_ID_VAL;       // RL5
      rd_cap[`NEXT_PTR_LSB +: 8]         = `NEXT_CAP_PTR_VAL;        // RL6
      rd_cap[`CAP_VER_LSB +: 4]          = `CAP_VERSION_VAL;         // RL7
      rd_cap[`PORT_TYPE_LSB +: 4]        = port_type;                // RL8
      rd_cap[`SLOT_IMPL_BIT]             = slot_implemented;         // RL9
      rd_cap[`IRQ_MSG_NUM_LSB +: 5]      = `IRQ_MSG_NUM_VAL;         // RL10
      // device capabilities
      rd_dcap[`MAX_PAYLOAD_LSB +: 3]     = max_payload_supported;    // RL11
      rd_dcap[`PHANTOM_FN_LSB +: 2]      = `PHANTOM_FN_VAL;          // RL12
      rd_dcap[`EXT_TAG_BIT]              = `EXT_TAG_VAL;             // RL13
      // latencies read seven, not three
      rd_dcap[`L0S_LATENCY_LSB +: 3]     = `L0S_LATENCY_VAL;         // RL14
      rd_dcap[`L1_LATENCY_LSB +: 3]      = `L1_LATENCY_VAL;          // RL15
      rd_dcap[`INDICATORS_LSB +: 3]      = indicators_q;             // RL16
   end

   // word select; dwords of other banks
   // read zero here RL17
   always_comb begin
      case (acc.dw_index)
         LEGACY_DW: rd_word = rd_legacy;
         CAP_DW:    rd_word = rd_cap;
         DCAP_DW:   rd_word = rd_dcap;
         default:   rd_word = 32'h0000_0000;
      endcase
   end

   // bank state: routing byte storage and the registered answers
   always_comb begin
      nxt_st         = st_ff;
      nxt_st.cfg_ack = 1'b0;
      nxt_st.mem_ack = 1'b0;
      // routing byte stores any write; it is plain
      // storage, so no lock applies RL1
      if (wr_legacy && acc.be[ROUTING_LN]) begin
         nxt_st.irq_routing = acc.wdata[{ROUTING_LN, 3'h0} +: 8];     // RL1
      end
      // answer one cycle after grant
      if (acc.valid) begin
         if (acc.src == ntb_cap_pkg::SRC_CFG) begin
            nxt_st.cfg_ack   = 1'b1;
            nxt_st.cfg_rdata = (acc.hit && !acc.wr) ? rd_word : 32'h0000_0000;
         end else begin
            // window reads see the config image RL18
            nxt_st.mem_ack   = 1'b1;
            nxt_st.mem_rdata = (acc.hit && !acc.wr) ? rd_word : 32'h0000_0000;
         end
      end
   end

   // state register
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         st_ff <= '{irq_routing: `IRQ_ROUTING_RST, default: '0};
      end else begin
         st_ff <= nxt_st;
      end
   end

   // answers come straight from flops
   assign cfg_ack   = st_ff.cfg_ack;
   assign cfg_rdata = st_ff.cfg_rdata;
   assign mem_ack   = st_ff.mem_ack;
   assign mem_rdata = st_ff.mem_rdata;

endmodule : nt_bridge_pcie_cap_regs
`default_nettype wire

// ### verif/cap_regs_properties.sv
`timescale 1ns/1ps
`default_nettype none
// read answers and exported values of the bank
module cap_regs_checker (
   // clock and reset
   input wire logic        ref_clk,
   input wire logic        resetn,
   // access answers
   input wire logic        cfg_ack,
   input wire logic        cfg_wr,
   input wire logic [11:0] cfg_addr,
   input wire logic [31:0] cfg_rdata,
   input wire logic        mem_ack,
   input wire logic        mem_wr,
   input wire logic [31:0] mem_addr,
   input wire logic [31:0] mem_rdata,
   input wire logic [19:0] window_base_hi,
   // lock and loader
   input wire logic        regs_locked,
   input wire logic        eeprom_ld,
   // exported values
   input wire logic [3:0]  port_type,
   input wire logic        slot_implemented,
   input wire logic [2:0]  max_payload_supported,
   input wire logic        attention_button_present,
   input wire logic        attention_indicator_present,
   input wire logic        power_indicator_present
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   // decoded read answers; the address is still held in the ack cycle
   logic tail_rd, cap_rd, dcap_rd;
   logic [2:0] ind;
   assign tail_rd = cfg_ack && !cfg_wr && cfg_addr[11:2] == 10'h00F;
   assign cap_rd = cfg_ack && !cfg_wr && cfg_addr[11:2] == 10'h010;
   assign dcap_rd = cfg_ack && !cfg_wr && cfg_addr[11:2] == 10'h011;
   assign ind = {power_indicator_present, attention_indicator_present, attention_button_present};
   property p_cap_fixed; cap_rd |-> cfg_rdata[19:0] == 20'h16410; endproperty
   a_cap_fixed: assert property (p_cap_fixed) else $error("cap fixed fields");
   property p_cap_type; cap_rd |-> cfg_rdata[24:20] == {slot_implemented, port_type}; endproperty
   a_cap_type: assert property (p_cap_type) else $error("cap type or slot");
   property p_cap_resv; cap_rd |-> cfg_rdata[31:25] == 7'h00; endproperty
   a_cap_resv: assert property (p_cap_resv) else $error("cap upper bits");
   property p_dcap_fixed; dcap_rd |-> cfg_rdata[11:3] == 9'h1FC; endproperty
   a_dcap_fixed: assert property (p_dcap_fixed) else $error("dcap fixed");
   property p_dcap_var; dcap_rd |-> {cfg_rdata[14:12], cfg_rdata[2:0]} == {ind, max_payload_supported};
   endproperty
   a_dcap_var: assert property (p_dcap_var) else $error("dcap variable fields");
   property p_dcap_resv; dcap_rd |-> cfg_rdata[31:15] == 17'h00000; endproperty
   a_dcap_resv: assert property (p_dcap_resv) else $error("dcap reserved");
   property p_tail; tail_rd |-> cfg_rdata[31:16] == 16'h0000; endproperty
   a_tail: assert property (p_tail) else $error("grant or latency byte");
   property p_win_miss; mem_ack && !mem_wr && mem_addr[31:12] != window_base_hi |-> mem_rdata == 0;
   endproperty
   a_win_miss: assert property (p_win_miss) else $error("window miss read");
   property p_rst_vals; !$past(resetn) |-> {port_type, slot_implemented, max_payload_supported, ind}
      == {4'h0, 1'b0, 3'h4, 3'h0}; endproperty
   a_rst_vals: assert property (p_rst_vals) else $error("reset values");
   // lock holds port type, slot and max payload unless the loader wrote
   property p_lock; $past(regs_locked) && !$past(eeprom_ld) |-> $stable({port_type,
      slot_implemented, max_payload_supported}); endproperty
   a_lock: assert property (p_lock) else $error("locked field changed");
   c_cap: cover property (cap_rd);
   c_win_wr: cover property (mem_ack && mem_wr);
   c_locked_wr: cover property (cfg_ack && cfg_wr && regs_locked);
endmodule : cap_regs_checker
bind nt_bridge_pcie_cap_regs cap_regs_checker cap_regs_checker_i (.*);
`default_nettype wire

// ### verif/cfg_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// requester on one access port: holds a request until its ack is seen
module cfg_host_model #(parameter int AW = 12) (
   // clock
   input  wire logic          ref_clk,
   // answer
   input  wire logic          ack,
   input  wire logic [31:0]   rdata,
   // request
   output logic               req,
   output logic               wr,
   output logic [AW-1:0]      addr,
   output logic [31:0]        wdata,
   output logic [3:0]         be
);
   initial {req, wr, addr, wdata, be} = '0;
   // one dword; gives up after 20 edges so a dead bank cannot hang the run
   task automatic access(input logic w, input logic [AW-1:0] a, input logic [31:0] d,
                         input logic [3:0] b, output logic [31:0] q, output logic ok);
      ok = 1'b0;
      q = 32'h0;
      @(posedge ref_clk);
      req <= 1'b1;
      wr <= w;
      addr <= a;
      wdata <= d;
      be <= b;
      for (int n = 0; n < 20 && !ok; n++) begin
         @(posedge ref_clk);
         #1;
         ok = ack;
         q = rdata;
      end
      // released address and data lines do not keep their last value
      @(posedge ref_clk);
      req <= 1'b0;
      addr <= ~a;
      wdata <= ~d;
   endtask : access
endmodule : cfg_host_model
`default_nettype wire

// ### verif/test_nt_bridge_pcie_cap_regs.sv
`timescale 1ns/1ps
`default_nettype none
module test_nt_bridge_pcie_cap_regs;
   logic        ref_clk, resetn, regs_locked, eeprom_ld, ok;
   logic        cfg_req, cfg_wr, cfg_ack, mem_req, mem_wr, mem_ack;
   logic        slot_implemented, attention_button_present;
   logic        attention_indicator_present, power_indicator_present;
   logic [2:0]  max_payload_supported, ind;
   logic [3:0]  cfg_be, mem_be, eeprom_ld_be, port_type;
   logic [7:0]  caps;
   logic [11:0] cfg_addr, eeprom_ld_addr;
   logic [19:0] window_base_hi;
   logic [31:0] mem_addr, cfg_wdata, mem_wdata, cfg_rdata, mem_rdata, eeprom_ld_data, rd;
   int          error_cnt, compares;
   localparam logic [19:0] BASE = 20'hABCDE;
   assign caps = {port_type, slot_implemented, max_payload_supported};
   assign ind = {power_indicator_present, attention_indicator_present, attention_button_present};
   nt_bridge_pcie_cap_regs nt_bridge_pcie_cap_regs_i (.*);
   cfg_host_model #(.AW(12)) cfg_host_model_i (.ref_clk(ref_clk), .ack(cfg_ack),
      .rdata(cfg_rdata), .req(cfg_req), .wr(cfg_wr), .addr(cfg_addr), .wdata(cfg_wdata),
      .be(cfg_be));
   cfg_host_model #(.AW(32)) cfg_host_model_win_i (.ref_clk(ref_clk), .ack(mem_ack),
      .rdata(mem_rdata), .req(mem_req), .wr(mem_wr), .addr(mem_addr), .wdata(mem_wdata),
      .be(mem_be));
   always #5 ref_clk = ~ref_clk;
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         error_cnt++;
         $display("BAD %s exp %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic report_and_stop();
      $display("errors %0d compares %0d", error_cnt, compares);
      if (error_cnt == 0 && compares > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : report_and_stop
   // m=1 uses the window; a lost ack ends the run
   task automatic acc(input logic m, input logic w, input logic [31:0] a, input logic [31:0] d,
                      input logic [3:0] b);
      if (m) begin
         cfg_host_model_win_i.access(w, a, d, b, rd, ok);
      end else begin
         cfg_host_model_i.access(w, a[11:0], d, b, rd, ok);
      end
      if (ok !== 1'b1) begin
         error_cnt++;
         report_and_stop();
      end
   endtask : acc
   task automatic rc(input logic m, input logic [31:0] a, input logic [31:0] exp, input string nm);
      acc(m, 1'b0, a, 32'h0, 4'h0);
      chk(nm, rd, exp);
   endtask : rc
   // loader word, one cycle pulse
   task automatic load(input logic [11:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      eeprom_ld <= 1'b1;
      eeprom_ld_addr <= a;
      eeprom_ld_data <= d;
      @(posedge ref_clk);
      eeprom_ld <= 1'b0;
   endtask : load
   initial begin
      {ref_clk, resetn, regs_locked, eeprom_ld, eeprom_ld_addr, eeprom_ld_data} = '0;
      {error_cnt, compares} = '0;
      eeprom_ld_be = 4'hF;
      window_base_hi = BASE;
      repeat (3) @(posedge ref_clk);
      resetn <= 1'b1;
      @(posedge ref_clk);
      #1;
      chk("outs rst", {caps, ind}, 32'h020);
      rc(0, 32'h03C, 32'h0, "tail rst");
      rc(0, 32'h040, 32'h00016410, "cap rst");
      rc(0, 32'h044, 32'h00000FE4, "dcap rst");
      acc(0, 1, 32'h03C, 32'hA5A5C3AB, 4'hF);
      rc(0, 32'h03C, 32'h0000C3AB, "tail wr");
      acc(0, 1, 32'h040, 32'hFFFFFFFF, 4'hF);
      rc(0, 32'h040, 32'h01F16410, "cap wr");
      acc(0, 1, 32'h044, 32'hFFFFFFFF, 4'hF);
      rc(0, 32'h044, 32'h00000FE7, "dcap wr");
      chk("outs wr", caps, 32'hFF);
      @(posedge ref_clk);
      regs_locked <= 1'b1;
      acc(0, 1, 32'h03C, 32'h000011CD, 4'hF);
      rc(0, 32'h03C, 32'h0000C3CD, "tail lock");
      acc(0, 1, 32'h040, 32'h0, 4'hF);
      rc(0, 32'h040, 32'h01F16410, "cap lock");
      acc(0, 1, 32'h044, 32'h0, 4'hF);
      rc(0, 32'h044, 32'h00000FE7, "dcap lock");
      load(12'h044, 32'h00007002);
      load(12'h040, 32'h00300000);
      rc(0, 32'h044, 32'h00007FE2, "dcap load");
      rc(0, 32'h040, 32'h00316410, "cap load");
      chk("ind load", ind, 32'h7);
      rc(0, 32'h048, 32'h0, "unmapped");
      rc(1, {BASE, 12'h040}, 32'h00316410, "win cap");
      rc(1, {BASE + 20'h1, 12'h040}, 32'h0, "win miss");
      acc(1, 1, {BASE, 12'h03C}, 32'h00000077, 4'h1);
      acc(1, 1, {BASE - 20'h1, 12'h03C}, 32'h00000011, 4'h1);
      rc(1, {BASE, 12'h03C}, 32'h0000C377, "win wr");
      @(posedge ref_clk);
      resetn <= 1'b0;
      repeat (3) @(posedge ref_clk);
      resetn <= 1'b1;
      rc(0, 32'h040, 32'h00016410, "cap rerst");
      rc(0, 32'h03C, 32'h0, "tail rerst");
      report_and_stop();
   end
endmodule : test_nt_bridge_pcie_cap_regs
`default_nettype wire
